// >>> design/event_notify_pkg.sv
package event_notify_pkg;

  localparam int unsigned DATA_W         = 16;
  localparam int unsigned ADDR_W         = 16;
  localparam int unsigned NUM_SRC        = 10;
  localparam int unsigned SRC_LSB        = 6;
  localparam int unsigned CFG_W          = 3;

  localparam logic [15:0] STD_MASK_ADDR  = 16'h008e;
  localparam logic [15:0] FORCE_ADDR     = 16'h0090;
  localparam logic [15:0] FLAG_ADDR      = 16'h001c;
  localparam logic [15:0] CRIT_MASK_ADDR = 16'h008c;
  localparam logic [15:0] CLEAR_ADDR     = 16'h0092;

  localparam logic [15:0] STD_MASK_RESET = 16'h0000;
  localparam logic [15:0] FORCE_RESET    = 16'h0000;
  localparam logic [15:0] IMPL_BITS      = 16'hffc0;

  localparam logic [2:0]  CFG_STD_OUT    = 3'h5;
  localparam logic [2:0]  CFG_CRIT_OUT   = 3'h4;

  localparam int unsigned EXCESS_CURRENT      = 15;
  localparam int unsigned EXCESS_LINE_VOLTAGE = 14;
  localparam int unsigned EXCESS_POWER        = 13;
  localparam int unsigned LOW_LINE_VOLTAGE    = 12;
  localparam int unsigned HIGH_LINE_FREQUENCY = 11;
  localparam int unsigned LOW_LINE_FREQUENCY  = 10;
  localparam int unsigned HIGH_TEMPERATURE    = 9;
  localparam int unsigned LOW_TEMPERATURE     = 8;
  localparam int unsigned LINE_VOLTAGE_DIP    = 7;
  localparam int unsigned LINE_VOLTAGE_SWELL  = 6;

endpackage : event_notify_pkg

// >>> design/event_flag_slice.sv
`timescale 1ns/1ns
// One event source: latched flag plus its force bit
module event_flag_slice (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic real_event,
  input  wire logic force_wr,
  input  wire logic force_wdata,
  input  wire logic clear_pulse,
  output logic      force_bit,
  output logic      flag,
  output logic      real_latched
);

  logic next_force_bit;
  logic next_real_latched;

  always_comb begin
    next_force_bit    = force_bit;
    next_real_latched = real_latched;
    if (force_wr) begin
      next_force_bit = force_wdata;
    end
    if (clear_pulse && force_bit) begin
      next_force_bit = 1'b0;
    end
    if (clear_pulse && !real_event) begin
      next_real_latched = 1'b0;
    end
    // Set wins over clear
    if (real_event) begin
      next_real_latched = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      force_bit    <= 1'b0;
      real_latched <= 1'b0;
    end else begin
      force_bit    <= next_force_bit;
      real_latched <= next_real_latched;
    end
  end

  assign flag = real_latched | force_bit;

endmodule : event_flag_slice

// >>> design/notify_pin_driver.sv
`timescale 1ns/1ns
// Drives one multipurpose pin from its configuration field
module notify_pin_driver (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [2:0] pin_cfg,
  input  wire logic       std_level,
  input  wire logic       crit_level,
  output logic            pin_out,
  output logic            pin_oe_n
);

  logic next_pin_out;
  logic next_pin_oe_n;

  always_comb begin
    next_pin_out  = 1'b0;
    next_pin_oe_n = 1'b1;
    case (pin_cfg)
      event_notify_pkg::CFG_STD_OUT: begin
        next_pin_out  = std_level;
        next_pin_oe_n = 1'b0;
      end
      event_notify_pkg::CFG_CRIT_OUT: begin
        next_pin_out  = crit_level;
        next_pin_oe_n = 1'b0;
      end
      default: begin
        next_pin_out  = 1'b0;
        next_pin_oe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out  <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
    end
  end

endmodule : notify_pin_driver

// >>> design/event_notify_mask_and_test.sv
`timescale 1ns/1ns
module event_notify_mask_and_test #(
  parameter int unsigned NUM_PINS = 4
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic [15:0]           reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [15:0]           reg_wdata,
  output logic      [15:0]           reg_rdata,
  output logic                       reg_hit,
  input  wire logic [9:0]            limit_event,
  input  wire logic [15:0]           crit_mask,
  input  wire logic [NUM_PINS*3-1:0] pin_cfg,
  output logic      [15:0]           event_flags,
  output logic                       std_notify,
  output logic                       crit_notify,
  output logic      [NUM_PINS-1:0]   multipurpose_pin_out,
  output logic      [NUM_PINS-1:0]   multipurpose_pin_oe_n
);

  logic [15:0] standard_alert_mask;
  logic [15:0] next_standard_alert_mask;
  logic [15:0] event_force;
  logic [15:0] next_reg_rdata;
  logic        next_reg_hit;
  logic [15:0] flag_vec;
  logic        wr_mask;
  logic        wr_force;
  logic        wr_clear;

  assign wr_mask  = reg_wr && (reg_addr == event_notify_pkg::STD_MASK_ADDR);
  assign wr_force = reg_wr && (reg_addr == event_notify_pkg::FORCE_ADDR);
  assign wr_clear = reg_wr && (reg_addr == event_notify_pkg::CLEAR_ADDR);

  always_comb begin
    next_standard_alert_mask = standard_alert_mask;
    if (wr_mask) begin
      next_standard_alert_mask = reg_wdata & event_notify_pkg::IMPL_BITS;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      standard_alert_mask <= event_notify_pkg::STD_MASK_RESET;
    end else begin
      standard_alert_mask <= next_standard_alert_mask;
    end
  end

  assign flag_vec[5:0]    = 6'h00;
  assign event_force[5:0] = 6'h00;

  genvar g;
  generate
    for (g = 0; g < event_notify_pkg::NUM_SRC; g++) begin : g_src
      logic force_bit;
      logic flag_bit;
      event_flag_slice u_slice (
        .mclk         (mclk),
        .rst          (rst),
        .real_event   (limit_event[g]),
        .force_wr     (wr_force),
        .force_wdata  (reg_wdata[g+event_notify_pkg::SRC_LSB]),
        .clear_pulse  (wr_clear && reg_wdata[g+event_notify_pkg::SRC_LSB]),
        .force_bit    (force_bit),
        .flag         (flag_bit),
        .real_latched ()
      );
      assign flag_vec[g+event_notify_pkg::SRC_LSB]    = flag_bit;
      assign event_force[g+event_notify_pkg::SRC_LSB] = force_bit;
    end
  endgenerate

  assign event_flags = flag_vec;

  assign std_notify  = |(flag_vec & standard_alert_mask);
  assign crit_notify = |(flag_vec & crit_mask & event_notify_pkg::IMPL_BITS);

  always_comb begin
    next_reg_rdata = 16'h0000;
    next_reg_hit   = 1'b0;
    if (reg_rd) begin
      next_reg_hit = 1'b1;
      case (reg_addr)
        event_notify_pkg::STD_MASK_ADDR: begin
          next_reg_rdata = standard_alert_mask & event_notify_pkg::IMPL_BITS;
        end
        event_notify_pkg::FORCE_ADDR: begin
          next_reg_rdata = event_force & event_notify_pkg::IMPL_BITS;
        end
        event_notify_pkg::FLAG_ADDR: begin
          next_reg_rdata = flag_vec;
        end
        default: begin
          next_reg_rdata = 16'h0000;
          next_reg_hit   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
      reg_hit   <= 1'b0;
    end else begin
      reg_rdata <= next_reg_rdata;
      reg_hit   <= next_reg_hit;
    end
  end

  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      notify_pin_driver u_pin (
        .mclk       (mclk),
        .rst        (rst),
        .pin_cfg    (pin_cfg[g*3 +: 3]),
        .std_level  (std_notify),
        .crit_level (crit_notify),
        .pin_out    (multipurpose_pin_out[g]),
        .pin_oe_n   (multipurpose_pin_oe_n[g])
      );
    end
  endgenerate

endmodule : event_notify_mask_and_test

// >>> dv/event_notify_props.sv
`timescale 1ns/1ns
module event_notify_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_hit,
  input wire logic [9:0]  limit_event,
  input wire logic [15:0] event_flags,
  input wire logic        std_notify
);
  // Mask rebuilt from write strobes, so no hidden state is needed
  logic [15:0] m;
  logic [15:0] next_m;
  always_comb next_m = (reg_wr && reg_addr == 16'h008e) ? (reg_wdata & 16'hffc0) : m;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) m <= 16'h0000;
    else m <= next_m;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_STD_OR: assert property (std_notify == |(event_flags & m))
    else $error("std pin mismatch");
  AST_LOW_FLAGS: assert property (event_flags[5:0] == 6'h00)
    else $error("low flag bits set");
  AST_LOW_READ: assert property (reg_hit |-> reg_rdata[5:0] == 6'h00)
    else $error("low read bits set");
  AST_MASK_READ: assert property (reg_rd && reg_addr == 16'h008e |=> reg_hit && reg_rdata == $past(m))
    else $error("mask read wrong");
  AST_FORCE_SETS: assert property (reg_wr && reg_addr == 16'h0090 |=> &(event_flags[15:6] | ~$past(reg_wdata[15:6])))
    else $error("forced flag missing");
  AST_REAL_HOLDS: assert property (|limit_event |=> &(event_flags[15:6] | ~$past(limit_event)))
    else $error("real flag missing");
  AST_FALL_CAUSE: assert property (|($past(event_flags) & ~event_flags) |-> $past(reg_wr))
    else $error("flag fell without write");
  AST_CLEAR: assert property (reg_wr && reg_addr == 16'h0092
    |=> (event_flags[15:6] & $past(reg_wdata[15:6] & ~limit_event)) == 10'h000)
    else $error("clear left flag");
  AST_NO_HIT: assert property (!(reg_rd && (reg_addr == 16'h008e || reg_addr == 16'h0090 || reg_addr == 16'h001c))
    |=> !reg_hit && reg_rdata == 16'h0000)
    else $error("stray read answer");
  cover property (std_notify);
  cover property (reg_wr && reg_addr == 16'h0092);
  cover property (reg_hit);
endmodule : event_notify_props
bind event_notify_mask_and_test event_notify_props u_props (.*);

// >>> dv/host_model.sv
`timescale 1ns/1ns
module host_model (
  input  wire logic        mclk,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_hit,
  output logic      [15:0] reg_addr = 16'hffff,
  output logic             reg_wr = 1'b0,
  output logic             reg_rd = 1'b0,
  output logic      [15:0] reg_wdata = 16'hffff
);
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    // Released lines flip so a stale value never looks valid
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic h);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    h = reg_hit;
  endtask : rd
endmodule : host_model

// >>> dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [9:0]  limit_event = 10'h000;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, event_flags, d;
  logic        reg_wr, reg_rd, reg_hit, std_notify, crit_notify, h;
  logic [3:0]  pin_out, pin_oe_n;
  int          bad_count = 0;
  int          n_compared = 0;
  always #20 mclk = ~mclk;
  host_model u_host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_hit(reg_hit), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  event_notify_mask_and_test #(.NUM_PINS(4)) u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .limit_event(limit_event), .crit_mask(16'h4000), .pin_cfg(12'h4a5), .event_flags(event_flags),
    .std_notify(std_notify), .crit_notify(crit_notify), .multipurpose_pin_out(pin_out),
    .multipurpose_pin_oe_n(pin_oe_n));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  task automatic s_reset;
    u_host.rd(16'h008e, d, h);
    chk({h, d[14:0]}, 16'h8000);
    u_host.rd(16'h0090, d, h);
    chk({h, d[14:0]}, 16'h8000);
  endtask : s_reset
  task automatic s_mask;
    u_host.wr(16'h008e, 16'hffff);
    u_host.rd(16'h008e, d, h);
    chk(d, 16'hffc0);
    u_host.wr(16'h0090, 16'h8000);
    chk(16'(std_notify), 16'h0001);
    @(negedge mclk);
    chk({pin_out[1:0], pin_oe_n}, 16'h001c);
    u_host.rd(16'h001c, d, h);
    chk(d, 16'h8000);
    for (int i = 6; i < 16; i++) begin
      u_host.wr(16'h0090, 16'h0001 << i);
      u_host.wr(16'h008e, 16'h0001 << i);
      chk(16'(std_notify), 16'h0001);
      u_host.wr(16'h008e, ~(16'h0001 << i));
      chk(16'(std_notify), 16'h0000);
    end
    u_host.wr(16'h0090, 16'h0000);
    chk(event_flags, 16'h0000);
    // Pin 1 is the critical output, its mask holds bit 14 only
    u_host.wr(16'h0090, 16'h4000);
    chk(16'(crit_notify), 16'h0001);
    @(negedge mclk);
    chk(16'(pin_out), 16'h0003);
    u_host.wr(16'h0090, 16'h0000);
    chk(16'(crit_notify), 16'h0000);
  endtask : s_mask
  task automatic s_real;
    @(negedge mclk);
    limit_event = 10'h200;
    u_host.wr(16'h0092, 16'h8000);
    chk(event_flags, 16'h8000);
    limit_event = 10'h000;
    u_host.wr(16'h0090, 16'h0000);
    chk(event_flags, 16'h8000);
    u_host.wr(16'h0092, 16'h8000);
    chk(event_flags, 16'h0000);
    u_host.wr(16'h0090, 16'h0100);
    u_host.wr(16'h0092, 16'h0100);
    u_host.rd(16'h0090, d, h);
    chk(d, 16'h0000);
  endtask : s_real
  task automatic s_refuse;
    u_host.rd(16'h0000, d, h);
    chk({h, d[14:0]}, 16'h0000);
    u_host.wr(16'h001c, 16'hffff);
    chk(event_flags, 16'h0000);
  endtask : s_refuse
  initial begin
    #100000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    s_reset;
    s_mask;
    s_real;
    s_refuse;
    rst = 1'b1;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    s_reset;
    report_and_stop;
  end
endmodule : tb_top
